/* File: src/sram_host.sv */
// Behaviour
// - Four active-low byte selects pick bytes independently.
// - Host reads two density lines to learn module density.
// - Write interval is where select and strobe are both low.
// - Address is valid no later than the last byte select falls.
// - Module is deselected before retention begins, zero ns minimum.
`timescale 1ns/1ps
`default_nettype none
module sram_host
  import sram_host_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire sram_req_t req_i,
  input wire logic retain_req_i,
  input wire logic [1:0] density_code_i,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic density_match_o,
  output logic retain_o,
  output sram_pins_t pins_o,
  output logic [DATA_W-1:0] data_lines_o,
  output logic [DATA_W-1:0] data_lines_oe_o
);

  host_state_t state;
  host_state_t next_state;
  logic [CNT_W-1:0] cnt;
  sram_req_t cur;
  logic req_ready;
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  logic density_match;
  logic retain;
  sram_pins_t pins;
  logic ld;
  logic drv;

  wire logic cnt_done = (cnt == '0);
  wire logic take = req_ready & req_valid_i;
  wire logic take_retain = (state == ST_IDLE) & retain_req_i;
  // Retention is asked while idle; a pending access waits for recovery.
  wire logic go_access = take & ~retain_req_i & (state == ST_IDLE);
  wire logic in_read = (state == ST_READ);
  wire logic selected = (state == ST_SETUP) | (state == ST_STROBE) |
                        (state == ST_HOLD) | in_read;
  wire logic any_lane = |cur.lanes;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_retain) begin
          next_state = ST_RETAIN;
        end else if (go_access) begin
          next_state = req_i.write ? ST_SETUP : ST_READ;
        end
      end
      ST_SETUP: next_state = ST_STROBE;
      ST_STROBE: next_state = cnt_done ? ST_HOLD : ST_STROBE;
      ST_HOLD: next_state = ST_IDLE;
      ST_READ: next_state = cnt_done ? ST_IDLE : ST_READ;
      ST_RETAIN: next_state = retain_req_i ? ST_RETAIN : ST_RECOVER;
      ST_RECOVER: next_state = cnt_done ? ST_IDLE : ST_RECOVER;
      default: next_state = ST_IDLE;
    endcase
  end

  assign ld = go_access;
  assign drv = (next_state == ST_SETUP) | (next_state == ST_STROBE) |
               (next_state == ST_HOLD);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      cnt <= '0;
      cur <= '0;
    end else begin
      state <= next_state;
      if (ld) begin
        cur <= req_i;
      end
      if (go_access && !req_i.write) begin
        cnt <= CNT_W'(READ_CYCLES - 1);
      end else if (state == ST_SETUP) begin
        cnt <= CNT_W'(WRITE_CYCLES - 1);
      end else if (take_retain) begin
        cnt <= CNT_W'(RETAIN_CYCLES - 1);
      end else if (state == ST_RETAIN) begin
        cnt <= CNT_W'(RECOVERY_CYCLES - 1);
      end else if (!cnt_done) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pins.word_index <= '0;
      pins.write_n <= 1'b1;
      pins.drive_n <= 1'b1;
      pins.byte_select_n <= '1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      density_match <= 1'b0;
      retain <= 1'b0;
    end else begin
      // Address is set in the same edge as the selects fall.
      if (ld) begin
        pins.word_index <= req_i.word_index;
      end
      // Only the requested lanes are selected.
      pins.byte_select_n <= (next_state == ST_READ ||
                             next_state == ST_SETUP ||
                             next_state == ST_STROBE ||
                             next_state == ST_HOLD) ?
                            ~(ld ? req_i.lanes : cur.lanes) : '1;
      // Strobe low only inside selects, framed by setup and hold.
      // A write with no lane selected leaves the strobe high as well.
      pins.write_n <= ~((next_state == ST_STROBE) & any_lane);
      // Drive control low only on reads, so the module floats otherwise.
      pins.drive_n <= (next_state != ST_READ);
      req_ready <= (next_state == ST_IDLE) & ~retain_req_i;
      rsp_valid <= in_read & cnt_done;
      if (in_read && cnt_done) begin
        rsp_data <= data_lines_i;
      end
      density_match <= (density_code_i == DENSITY_OPEN);
      // Retention flag rises only after the selects went high.
      retain <= (state == ST_RETAIN) & ~selected;
    end
  end

  sram_lane_drv #(
    .LANES(BYTE_LANES)
  ) u_lane (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .load_i(ld),
    .drive_i(drv),
    .lanes_i(ld ? req_i.lanes : cur.lanes),
    .wdata_i(req_i.wdata),
    .data_lines_o(data_lines_o),
    .data_lines_oe_o(data_lines_oe_o)
  );

  assign req_ready_o = req_ready;
  assign rsp_valid_o = rsp_valid;
  assign rsp_data_o = rsp_data;
  assign density_match_o = density_match;
  assign retain_o = retain;
  assign pins_o = pins;

endmodule
`default_nettype wire

/* File: src/sram_host_pkg.sv */
`default_nettype none
package sram_host_pkg;

  localparam int WORD_INDEX_W = 17;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int BYTE_LANES = 4;

  // Both density lines open on this module; the socket pulls them high.
  localparam logic [1:0] DENSITY_OPEN = 2'h3;

  // Minimum times in ns; counts are derived from the 20 MHz clock.
  localparam int CLK_PERIOD_NS = 50;
  localparam int READ_CYCLE_NS = 25;
  localparam int WRITE_PULSE_NS = 15;
  localparam int DESELECT_TO_RETAIN_NS = 0;
  localparam int RECOVERY_NS = 25;

  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_CYCLES = ns_to_cycles(READ_CYCLE_NS);
  localparam int WRITE_CYCLES = ns_to_cycles(WRITE_PULSE_NS);
  localparam int RETAIN_CYCLES = ns_to_cycles(DESELECT_TO_RETAIN_NS);
  localparam int RECOVERY_CYCLES = ns_to_cycles(RECOVERY_NS);
  localparam int CNT_W = 4;

  typedef struct packed {
    logic write;
    logic [BYTE_LANES-1:0] lanes;
    logic [WORD_INDEX_W-1:0] word_index;
    logic [DATA_W-1:0] wdata;
  } sram_req_t;

  typedef struct packed {
    logic [WORD_INDEX_W-1:0] word_index;
    logic write_n;
    logic drive_n;
    logic [BYTE_LANES-1:0] byte_select_n;
  } sram_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_READ = 3'b100,
    ST_RETAIN = 3'b101,
    ST_RECOVER = 3'b110
  } host_state_t;

endpackage
`default_nettype wire

/* File: src/sram_lane_drv.sv */
`timescale 1ns/1ps
`default_nettype none
// Per-lane data driver: holds write data and enables only selected lanes.
module sram_lane_drv
  import sram_host_pkg::*;
#(
  parameter int LANES = BYTE_LANES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic drive_i,
  input wire logic [LANES-1:0] lanes_i,
  input wire logic [LANES*BYTE_W-1:0] wdata_i,
  output logic [LANES*BYTE_W-1:0] data_lines_o,
  output logic [LANES*BYTE_W-1:0] data_lines_oe_o
);

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [BYTE_W-1:0] hold;
    logic en;
    assign data_lines_o[g*BYTE_W +: BYTE_W] = hold;
    assign data_lines_oe_o[g*BYTE_W +: BYTE_W] = {BYTE_W{en}};
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        hold <= '0;
        en <= 1'b0;
      end else begin
        if (load_i) begin
          hold <= wdata_i[g*BYTE_W +: BYTE_W];
        end
        // Unselected lanes stay undriven, so the module keeps them.
        en <= drive_i & lanes_i[g];
      end
    end
  end

endmodule
`default_nettype wire

/* File: verif/sram_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_host_asserts
  import sram_host_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire sram_req_t req_i,
  input wire logic retain_req_i,
  input wire logic [1:0] density_code_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic density_match_o,
  input wire logic retain_o,
  input wire sram_pins_t pins_o,
  input wire logic [DATA_W-1:0] data_lines_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic tk;
  assign tk = req_valid_i && req_ready_o && !retain_req_i;
  rd_strobe_a: assert property (
    !pins_o.drive_n |-> pins_o.write_n)
    else $error("drive low with strobe low");
  no_fight_a: assert property (
    |data_lines_oe_o |-> pins_o.drive_n)
    else $error("host drives while module enabled");
  wr_sel_a: assert property (
    !pins_o.write_n |-> pins_o.byte_select_n != 4'hf)
    else $error("strobe without select");
  one_take_a: assert property (tk |=> !req_ready_o)
    else $error("ready stayed high");
  rd_answer_a: assert property (
    tk && !req_i.write |-> ##2 rsp_valid_o ##1 !rsp_valid_o)
    else $error("read answer late");
  wr_pulse_a: assert property (
    tk && req_i.write |->
      ##2 (pins_o.write_n == !(|$past(req_i.lanes, 2)))
      ##1 pins_o.write_n)
    else $error("write pulse wrong");
  rd_addr_a: assert property (
    tk |=> pins_o.word_index == $past(req_i.word_index))
    else $error("address not set");
  density_flag_a: assert property (
    $past(rst_n_i) |->
      density_match_o == ($past(density_code_i) == DENSITY_OPEN))
    else $error("density flag wrong");
  retain_desel_a: assert property (
    retain_o |-> pins_o.byte_select_n == 4'hf)
    else $error("selected in retention");
endmodule
bind sram_host sram_host_asserts u_chk (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .req_valid_i(req_valid_i),
  .req_i(req_i),
  .retain_req_i(retain_req_i),
  .density_code_i(density_code_i),
  .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o),
  .density_match_o(density_match_o),
  .retain_o(retain_o),
  .pins_o(pins_o),
  .data_lines_oe_o(data_lines_oe_o)
);
`default_nettype wire

/* File: verif/sram_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_host_tb;
  import sram_host_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, req_valid_i = 0, retain_req_i = 0;
  logic alt_dens = 1'b0;
  sram_req_t req_i = '0;
  logic [1:0] dens;
  logic [DATA_W-1:0] din, dout, doe, rsp_data_o;
  logic req_ready_o, rsp_valid_o, density_match_o, retain_o;
  sram_pins_t pins_o;
  logic [DATA_W-1:0] expq[$];
  logic [DATA_W-1:0] exp_mem [0:(1<<WORD_INDEX_W)-1];
  int miscompares = 0, samples_checked = 0, seed = 54714;
  always #25 clk_sys_i = ~clk_sys_i;
  sram_host dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .retain_req_i(retain_req_i),
    .density_code_i(dens), .data_lines_i(din), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .density_match_o(density_match_o), .retain_o(retain_o),
    .pins_o(pins_o), .data_lines_o(dout), .data_lines_oe_o(doe));
  sram_module_model mdl (.clk_sys_i(clk_sys_i), .pins_i(pins_o),
    .other_density_i(alt_dens), .host_d_i(dout), .host_oe_i(doe),
    .wire_o(din), .density_o(dens));
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h saw %h", nm, e, s);
    end
  endtask
  task automatic acc(logic w, logic [3:0] ln, logic [16:0] ix, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_i <= '{write: w, lanes: ln, word_index: ix, wdata: d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 50);
    if (req_ready_o !== 1'b1) chk("req_ready", 32'h0, 32'h1);
    req_valid_i <= 1'b0;
    if (w) begin
      for (int i = 0; i < 4; i++) if (ln[i]) exp_mem[ix][i*8+:8] = d[i*8+:8];
    end else expq.push_back(exp_mem[ix]);
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (expq.size() == 0) chk("spare_rsp", 32'h0, 32'h1);
      else
        chk("rsp_data", rsp_data_o, expq.pop_front());
    end
  end
  initial begin
    logic [16:0] ix;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("density", density_match_o, 1'b1);
    alt_dens <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("density_alt", density_match_o, 1'b0);
    alt_dens <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk("density_back", density_match_o, 1'b1);
    for (int k = 0; k < 12; k++) begin
      ix = (k == 0) ? 17'h1_ffff : 17'($random(seed));
      acc(1'b1, 4'hf, ix, $random(seed));
      acc(1'b1, 4'($random(seed)), ix, $random(seed));
      acc(1'b0, 4'hf, ix, 32'h0);
    end
    @(posedge clk_sys_i);
    retain_req_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("retain", retain_o, 1'b1);
    retain_req_i <= 1'b0;
    acc(1'b0, 4'hf, ix, 32'h0);
    repeat (6) @(posedge clk_sys_i);
    chk("retain_off", retain_o, 1'b0);
    chk("queue_left", 32'(expq.size()), 32'h0);
    summarize();
  end
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire

/* File: verif/sram_module_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_module_model
  import sram_host_pkg::*;
(
  input wire logic clk_sys_i,
  input wire sram_pins_t pins_i,
  input wire logic other_density_i,
  input wire logic [DATA_W-1:0] host_d_i,
  input wire logic [DATA_W-1:0] host_oe_i,
  output logic [DATA_W-1:0] wire_o,
  output logic [1:0] density_o
);
  logic [DATA_W-1:0] mem [0:(1<<WORD_INDEX_W)-1];
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] q;
  // Another density grounds a line; which one is arbitrary here.
  assign density_o = other_density_i ? 2'h1 : DENSITY_OPEN;
  // Undriven lanes show the inverse so a float never reads as a match.
  always_comb begin
    rd = mem[pins_i.word_index];
    for (int i = 0; i < BYTE_LANES; i++) begin
      q[i*8+:8] = (!pins_i.byte_select_n[i] && pins_i.write_n &&
        !pins_i.drive_n) ? rd[i*8+:8] : ~rd[i*8+:8];
    end
  end
  assign wire_o = (host_oe_i & host_d_i) | (~host_oe_i & q);
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < BYTE_LANES; i++) begin
      if (!pins_i.write_n && !pins_i.byte_select_n[i]) begin
        mem[pins_i.word_index][i*8+:8] <= wire_o[i*8+:8];
      end
    end
  end
endmodule
`default_nettype wire
